/* File: usp_pkg.sv */
// Purpose: shared constants and types of the serial port
// Assumes: 32-bit apb data, one aligned word per register
// Notes: timer overflow inputs come from logic on pclk
//
// Functional notes
// - mode 00: synchronous shift register, bit rate is pclk/2
// - mode 01: 8-bit async frames, rate from timer overflow
// - mode 10: 9-bit async frames, fixed rate pclk/64 or pclk/32
// - mode 11: 9-bit async frames, rate from timer overflow
// - mode 01 with multiproc set: bad stop bit leaves rx flag untouched
// - 9-bit modes with multiproc set: ninth bit zero gives no rx flag
// - multiproc clear: rx flag set when byte completes, no checks
// - receive only while rx enable set; clearing it stops async reception, a mode 00 shift in progress completes
// - 9-bit modes send tx ninth bit as ninth data bit
// - rx ninth bit latches ninth bit, or stop bit in mode 01
// - tx flag set after eighth bit or at stop start; software clears
// - rx flag set after eighth bit or at stop midpoint; software clears
// - data write loads transmitter; data read returns separate rx buffer
// - rx buffered; unread byte lost when next completes
// - variable modes: per-direction select of timer 2 or timer 1 overflow
package usp_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_RATE = 8'h08;
    localparam logic [7:0] OFS_STS = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic [2:0] STS_RESET = 3'h0;
    localparam int STS_TX = 0;
    localparam int STS_RX = 1;
    localparam int STS_OVR = 2;
    localparam int CORE_DIV_SLOW = 64;
    localparam int CORE_DIV_FAST = 32;
    localparam int OVERSAMPLE = 16;
    localparam logic [1:0] FIXED_SLOW_CNT = 2'(CORE_DIV_SLOW / OVERSAMPLE - 1);
    localparam logic [1:0] FIXED_FAST_CNT = 2'(CORE_DIV_FAST / OVERSAMPLE - 1);
    localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] TICK_HALF = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] SHIFT_LAST = 4'hF;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'h0,
        MODE_UART8 = 2'h1,
        MODE_UART9_FIXED = 2'h2,
        MODE_UART9_VAR = 2'h3
    } usp_mode_t;

    typedef struct packed {
        usp_mode_t mode;
        logic multiproc_enable;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } usp_ctrl_t;

    typedef struct packed {
        logic tx_rate_from_timer_two;
        logic rx_rate_from_timer_two;
        logic double_rate;
    } usp_rate_t;

    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_START = 6'h02,
        TX_DATA = 6'h04,
        TX_NINTH = 6'h08,
        TX_STOP = 6'h10,
        TX_SHIFT = 6'h20
    } usp_tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_NINTH = 5'h08,
        RX_STOP = 5'h10
    } usp_rx_state_t;
endpackage : usp_pkg

/* File: usp_rate_gen.sv */
// Purpose: 16x oversampling ticks for receiver and transmitter
// Assumes: timer overflow pulses are one pclk wide, same domain
// Notes: ticks are registered one-cycle pulses
`timescale 1ns/1ps
module usp_rate_gen (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    input usp_pkg::usp_mode_t mode,
    input usp_pkg::usp_rate_t rate,
    // timer overflows
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    // ticks
    output logic rx_tick,
    output logic tx_tick
);
    logic [1:0] div_reg;
    logic t1_half_reg;
    logic [1:0] div_last;
    logic fixed_tick;
    logic t1_tick;

    assign div_last = rate.double_rate ? usp_pkg::FIXED_FAST_CNT : usp_pkg::FIXED_SLOW_CNT;
    assign fixed_tick = (div_reg == div_last);
    // timer 1 path halves its overflow rate unless double rate is set
    assign t1_tick = timer1_ovf & (rate.double_rate | t1_half_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 2'h0;
        end else if (fixed_tick) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_half_reg <= 1'b0;
        end else if (timer1_ovf) begin
            t1_half_reg <= ~t1_half_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_tick <= 1'b0;
            tx_tick <= 1'b0;
        end else if (mode == usp_pkg::MODE_UART9_FIXED) begin
            rx_tick <= fixed_tick;
            tx_tick <= fixed_tick;
        end else begin
            rx_tick <= rate.rx_rate_from_timer_two ? timer2_ovf : t1_tick;
            tx_tick <= rate.tx_rate_from_timer_two ? timer2_ovf : t1_tick;
        end
    end
endmodule : usp_rate_gen

/* File: usp_serial_port.sv */
// Purpose: four-mode serial port with apb register access
// Assumes: apb3 master, zero-wait answer in first access cycle
// Notes: data writes while the transmitter is busy are dropped
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module usp_serial_port #(
    parameter int unsigned APB_ADDR_W = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer overflow pulses
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    // serial pins
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd,
    // interrupt
    output logic irq
);
    // the register map needs five address bits
    if (APB_ADDR_W < 5) begin : g_addr_check
        $error("APB_ADDR_W too small for register map");
    end

    usp_pkg::usp_ctrl_t ctrl_reg;
    usp_pkg::usp_rate_t rate_reg;
    usp_pkg::usp_tx_state_t tx_state_reg;
    usp_pkg::usp_rx_state_t rx_state_reg;
    logic [2:0] sts_reg;
    logic [2:0] mask_reg;
    logic [7:0] rx_buf_reg;
    logic [8:0] tx_shift_reg;
    logic [3:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic m0_rx_reg;
    logic m0_done_reg;
    logic [7:0] rx_shift_reg;
    logic [3:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic rx_ninth_reg;
    logic [1:0] rxd_sync_reg;
    logic rxd_prev_reg;
    logic rx_tick;
    logic tx_tick;

    function automatic logic nine_bit(input usp_pkg::usp_mode_t m);
        return m[1];
    endfunction : nine_bit

    function automatic logic hit(input logic [APB_ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == APB_ADDR_W'(ofs);
    endfunction : hit

    // apb decode
    logic setup;
    logic wr;
    logic mapped;
    logic [31:0] rd_mux;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;
    assign mapped = hit(paddr, usp_pkg::OFS_CTRL) | hit(paddr, usp_pkg::OFS_DATA)
        | hit(paddr, usp_pkg::OFS_RATE) | hit(paddr, usp_pkg::OFS_STS)
        | hit(paddr, usp_pkg::OFS_MASK);

    always_comb begin
        rd_mux = 32'h0;
        if (hit(paddr, usp_pkg::OFS_CTRL)) begin
            rd_mux = {24'h0, ctrl_reg};
        end else if (hit(paddr, usp_pkg::OFS_DATA)) begin
            rd_mux = {24'h0, rx_buf_reg};
        end else if (hit(paddr, usp_pkg::OFS_RATE)) begin
            rd_mux = {29'h0, rate_reg};
        end else if (hit(paddr, usp_pkg::OFS_STS)) begin
            rd_mux = {29'h0, sts_reg};
        end else if (hit(paddr, usp_pkg::OFS_MASK)) begin
            rd_mux = {29'h0, mask_reg};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= (setup & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    // serial events
    logic tx_load;
    logic tx_bit_end;
    logic tx_done_set;
    logic m0_rx_start;
    logic rx_mid;
    logic rx_stop_bit;
    logic rx_accept;
    logic rx_load;
    logic rx_ovr;
    assign tx_load = wr & hit(paddr, usp_pkg::OFS_DATA) & (tx_state_reg == usp_pkg::TX_IDLE);
    assign tx_bit_end = tx_tick & (tx_cnt_reg == usp_pkg::TICK_LAST);
    assign tx_done_set = (tx_bit_end & (tx_state_reg == usp_pkg::TX_NINTH
        | (tx_state_reg == usp_pkg::TX_DATA & tx_bit_reg == usp_pkg::BIT_LAST
        & ~nine_bit(ctrl_reg.mode))))
        | (tx_state_reg == usp_pkg::TX_SHIFT & ~m0_rx_reg
        & tx_cnt_reg == usp_pkg::SHIFT_LAST);
    assign m0_rx_start = ctrl_reg.mode == usp_pkg::MODE_SHIFT & ctrl_reg.rx_enable
        & ~ctrl_reg.rx_done_flag & ~m0_done_reg & ~tx_load;
    assign rx_mid = rx_tick & (rx_cnt_reg == usp_pkg::TICK_LAST);
    assign rx_stop_bit = rxd_sync_reg[1];
    // multiproc filter: stop bit in 8-bit mode, ninth bit otherwise
    assign rx_accept = rx_state_reg == usp_pkg::RX_STOP & rx_mid
        & (~ctrl_reg.multiproc_enable
        | (nine_bit(ctrl_reg.mode) ? rx_ninth_reg : rx_stop_bit));
    assign rx_load = rx_accept | m0_done_reg;
    assign rx_ovr = rx_load & ctrl_reg.rx_done_flag;

    usp_rate_gen u_rate (
        .pclk(pclk),
        .presetn(presetn),
        .mode(ctrl_reg.mode),
        .rate(rate_reg),
        .timer1_ovf(timer1_ovf),
        .timer2_ovf(timer2_ovf),
        .rx_tick(rx_tick),
        .tx_tick(tx_tick)
    );

    // control register; hardware set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= usp_pkg::CTRL_RESET;
        end else begin
            if (wr & hit(paddr, usp_pkg::OFS_CTRL)) begin
                ctrl_reg.mode <= usp_pkg::usp_mode_t'(pwdata[7:6]);
                ctrl_reg.multiproc_enable <= pwdata[5];
                ctrl_reg.rx_enable <= pwdata[4];
                ctrl_reg.tx_ninth_bit <= pwdata[3];
                ctrl_reg.rx_ninth_bit <= pwdata[2];
            end
            if (rx_accept) begin
                ctrl_reg.rx_ninth_bit <= nine_bit(ctrl_reg.mode) ? rx_ninth_reg
                    : rx_stop_bit;
            end
            // flags: writing zero clears, writing one leaves them
            ctrl_reg.tx_done_flag <= tx_done_set | (ctrl_reg.tx_done_flag
                & ~(wr & hit(paddr, usp_pkg::OFS_CTRL) & ~pwdata[1]));
            ctrl_reg.rx_done_flag <= rx_load | (ctrl_reg.rx_done_flag
                & ~(wr & hit(paddr, usp_pkg::OFS_CTRL) & ~pwdata[0]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_reg <= usp_pkg::RATE_RESET;
            mask_reg <= usp_pkg::STS_RESET;
        end else begin
            if (wr & hit(paddr, usp_pkg::OFS_RATE)) begin
                rate_reg <= pwdata[2:0];
            end
            if (wr & hit(paddr, usp_pkg::OFS_MASK)) begin
                mask_reg <= pwdata[2:0];
            end
        end
    end

    logic irq_src;
    assign irq_src = |(sts_reg & mask_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_reg <= usp_pkg::STS_RESET;
            irq <= 1'b0;
        end else begin
            sts_reg <= (sts_reg & ~((wr & hit(paddr, usp_pkg::OFS_STS)) ? pwdata[2:0] : 3'h0))
                | {rx_ovr, rx_load, tx_done_set};
            irq <= irq_src;
        end
    end

    // receive buffer, overwritten even when unread
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_reg <= 8'h00;
        end else if (m0_done_reg) begin
            rx_buf_reg <= tx_shift_reg[7:0];
        end else if (rx_accept) begin
            rx_buf_reg <= rx_shift_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_sync_reg <= 2'h3;
            rxd_prev_reg <= 1'b1;
        end else begin
            rxd_sync_reg <= {rxd_sync_reg[0], rxd_in};
            rxd_prev_reg <= rxd_sync_reg[1];
        end
    end

    // transmitter, also runs the shift register mode in both directions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= usp_pkg::TX_IDLE;
            tx_shift_reg <= 9'h1FF;
            tx_cnt_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
            m0_rx_reg <= 1'b0;
            m0_done_reg <= 1'b0;
            txd <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe <= 1'b0;
        end else begin
            m0_done_reg <= 1'b0;
            if (tx_tick & tx_state_reg != usp_pkg::TX_SHIFT) begin
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
            end
            unique case (tx_state_reg)
                usp_pkg::TX_IDLE: begin
                    tx_cnt_reg <= 4'h0;
                    if (tx_load & ctrl_reg.mode == usp_pkg::MODE_SHIFT) begin
                        tx_state_reg <= usp_pkg::TX_SHIFT;
                        tx_shift_reg <= {1'b0, pwdata[7:0]};
                        m0_rx_reg <= 1'b0;
                    end else if (tx_load) begin
                        tx_state_reg <= usp_pkg::TX_START;
                        tx_shift_reg <= {ctrl_reg.tx_ninth_bit, pwdata[7:0]};
                        txd <= 1'b0;
                    end else if (m0_rx_start) begin
                        tx_state_reg <= usp_pkg::TX_SHIFT;
                        m0_rx_reg <= 1'b1;
                    end
                end
                usp_pkg::TX_START: begin
                    if (tx_bit_end) begin
                        tx_state_reg <= usp_pkg::TX_DATA;
                        tx_bit_reg <= 4'h0;
                        txd <= tx_shift_reg[0];
                    end
                end
                usp_pkg::TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                        if (tx_bit_reg != usp_pkg::BIT_LAST) begin
                            txd <= tx_shift_reg[1];
                        end else if (nine_bit(ctrl_reg.mode)) begin
                            tx_state_reg <= usp_pkg::TX_NINTH;
                            txd <= tx_shift_reg[1];
                        end else begin
                            tx_state_reg <= usp_pkg::TX_STOP;
                            txd <= 1'b1;
                        end
                    end
                end
                usp_pkg::TX_NINTH: begin
                    if (tx_bit_end) begin
                        tx_state_reg <= usp_pkg::TX_STOP;
                        txd <= 1'b1;
                    end
                end
                usp_pkg::TX_STOP: begin
                    if (tx_bit_end) begin
                        tx_state_reg <= usp_pkg::TX_IDLE;
                    end
                end
                usp_pkg::TX_SHIFT: begin
                    // even phase: clock low, data out; odd phase: clock high, sample
                    tx_cnt_reg <= tx_cnt_reg + 4'h1;
                    txd <= tx_cnt_reg[0];
                    rxd_oe <= ~m0_rx_reg & ~tx_cnt_reg[0];
                    if (~tx_cnt_reg[0]) begin
                        rxd_out <= tx_shift_reg[0];
                    end else if (m0_rx_reg) begin
                        tx_shift_reg <= {1'b0, rxd_sync_reg[1], tx_shift_reg[7:1]};
                    end else begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
                    end
                    if (tx_cnt_reg == usp_pkg::SHIFT_LAST) begin
                        tx_state_reg <= usp_pkg::TX_IDLE;
                        txd <= 1'b1;
                        rxd_oe <= 1'b0;
                        m0_done_reg <= m0_rx_reg;
                    end
                end
            endcase
        end
    end

    // asynchronous receiver; shift register mode ignores multiproc
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_reg <= usp_pkg::RX_IDLE;
            rx_shift_reg <= 8'h00;
            rx_cnt_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            rx_ninth_reg <= 1'b0;
        end else if (~ctrl_reg.rx_enable | ctrl_reg.mode == usp_pkg::MODE_SHIFT) begin
            rx_state_reg <= usp_pkg::RX_IDLE;
        end else begin
            if (rx_tick) begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
            end
            unique case (rx_state_reg)
                usp_pkg::RX_IDLE: begin
                    rx_cnt_reg <= 4'h0;
                    if (rxd_prev_reg & ~rxd_sync_reg[1]) begin
                        rx_state_reg <= usp_pkg::RX_START;
                    end
                end
                usp_pkg::RX_START: begin
                    if (rx_tick & rx_cnt_reg == usp_pkg::TICK_HALF) begin
                        rx_cnt_reg <= 4'h0;
                        rx_bit_reg <= 4'h0;
                        // a glitch shorter than half a bit is no start bit
                        rx_state_reg <= rxd_sync_reg[1] ? usp_pkg::RX_IDLE
                            : usp_pkg::RX_DATA;
                    end
                end
                usp_pkg::RX_DATA: begin
                    if (rx_mid) begin
                        rx_shift_reg <= {rxd_sync_reg[1], rx_shift_reg[7:1]};
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == usp_pkg::BIT_LAST) begin
                            rx_state_reg <= nine_bit(ctrl_reg.mode) ? usp_pkg::RX_NINTH
                                : usp_pkg::RX_STOP;
                        end
                    end
                end
                usp_pkg::RX_NINTH: begin
                    if (rx_mid) begin
                        rx_ninth_reg <= rxd_sync_reg[1];
                        rx_state_reg <= usp_pkg::RX_STOP;
                    end
                end
                usp_pkg::RX_STOP: begin
                    if (rx_mid) begin
                        rx_state_reg <= usp_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // checks
    a_tx_flag_stop: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_state_reg == usp_pkg::TX_STOP) |-> ctrl_reg.tx_done_flag & txd)
        else $error("tx flag not set at stop bit start");
    a_mode0_clock: assert property (@(posedge pclk) disable iff (!presetn)
        tx_state_reg == usp_pkg::TX_SHIFT && $past(tx_state_reg) == usp_pkg::TX_SHIFT
        |-> txd != $past(txd))
        else $error("shift clock not at pclk/2");
    a_rx_disable: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_reg.rx_enable |=> rx_state_reg == usp_pkg::RX_IDLE)
        else $error("receiver runs while disabled");
    a_mp_filter: assert property (@(posedge pclk) disable iff (!presetn)
        rx_state_reg == usp_pkg::RX_STOP && rx_mid && nine_bit(ctrl_reg.mode)
        && ctrl_reg.multiproc_enable && !rx_ninth_reg && !ctrl_reg.rx_done_flag
        |=> !ctrl_reg.rx_done_flag)
        else $error("address filter passed ninth bit zero");
    a_stop_filter: assert property (@(posedge pclk) disable iff (!presetn)
        rx_accept && ctrl_reg.mode == usp_pkg::MODE_UART8 && ctrl_reg.multiproc_enable
        |=> ctrl_reg.rx_ninth_bit && ctrl_reg.rx_done_flag)
        else $error("bad stop bit accepted");
    a_stop_reject: assert property (@(posedge pclk) disable iff (!presetn)
        rx_state_reg == usp_pkg::RX_STOP && rx_mid && ctrl_reg.mode == usp_pkg::MODE_UART8
        && ctrl_reg.multiproc_enable && !rx_stop_bit && !ctrl_reg.rx_done_flag
        |=> !ctrl_reg.rx_done_flag)
        else $error("rx flag set on bad stop bit");
    a_ninth_sent: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_state_reg == usp_pkg::TX_NINTH) |-> txd == $past(tx_shift_reg[1]))
        else $error("ninth bit wrong on line");
    a_start_low: assert property (@(posedge pclk) disable iff (!presetn)
        tx_state_reg == usp_pkg::TX_START |-> !txd)
        else $error("start bit not low");
    a_write_loads: assert property (@(posedge pclk) disable iff (!presetn)
        tx_load |=> tx_state_reg != usp_pkg::TX_IDLE ##0 tx_shift_reg[7:0] == $past(pwdata[7:0]))
        else $error("data write did not load transmitter");
    a_rx_overrun: assert property (@(posedge pclk) disable iff (!presetn)
        rx_accept && ctrl_reg.rx_done_flag |=> sts_reg[usp_pkg::STS_OVR]
        && rx_buf_reg == $past(rx_shift_reg))
        else $error("overrun not reported");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == $past(irq_src))
        else $error("interrupt level wrong");
    c_uart8_rx: cover property (@(posedge pclk) disable iff (!presetn)
        rx_accept && ctrl_reg.mode == usp_pkg::MODE_UART8);
    c_uart9_tx: cover property (@(posedge pclk) disable iff (!presetn)
        tx_done_set && ctrl_reg.mode == usp_pkg::MODE_UART9_VAR);
    c_mode0_rx: cover property (@(posedge pclk) disable iff (!presetn) m0_done_reg);
    c_overrun: cover property (@(posedge pclk) disable iff (!presetn) rx_ovr);
endmodule : usp_serial_port

/* File: usp_remote_node.sv */
// Purpose: remote serial node facing the rx and tx pins
// Assumes: bit time given in pclk cycles
// Notes: node drives the rx pin from drv while rxd_oe is low; drv idles high, so an idle line reads high
`timescale 1ns/1ps
module usp_remote_node (
    // pins
    input wire logic pclk,
    input wire logic txd,
    input wire logic rxd_oe,
    input wire logic rxd_out,
    output logic rxd_pin
);
    logic drv = 1'b1;
    assign rxd_pin = rxd_oe ? rxd_out : drv;
    // start low, lsb first, then the chosen stop level
    task automatic send(input int bt, input int n, input logic [8:0] d, input logic stp);
        for (int i = 0; i < n + 2; i++) begin
            drv <= (i == 0) ? 1'b0 : (i > n) ? stp : d[i-1];
            repeat (bt) @(posedge pclk);
        end
        drv <= 1'b1;
    endtask : send
    task automatic recv(input int bt, input int n, output logic [10:0] f);
        f = '1;
        @(negedge txd);
        repeat (bt / 2) @(posedge pclk);
        for (int i = 0; i < n + 2; i++) begin
            f[i] = txd;
            repeat (bt) @(posedge pclk);
        end
    endtask : recv
endmodule : usp_remote_node

/* File: tb.sv */
// Purpose: self-checking bench of the serial port
// Assumes: timer overflows every 4 pclk
// Notes: bit time 64 pclk in modes 10 and 11, 128 in mode 01
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, rxd_in, rxd_out, rxd_oe, txd, irq;
    logic timer1_ovf = 1'b0;
    logic timer2_ovf = 1'b0;
    logic [1:0] tcnt = 2'h0;
    logic [10:0] fr;
    logic [7:0] sh;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    always #12.5 pclk = ~pclk;
    usp_serial_port i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer1_ovf(timer1_ovf),
        .timer2_ovf(timer2_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .txd(txd), .irq(irq));
    usp_remote_node i_node (.pclk(pclk), .txd(txd), .rxd_oe(rxd_oe),
        .rxd_out(rxd_out), .rxd_pin(rxd_in));
    task automatic final_report;
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // the limit is far above the few thousand cycles the frames need
    always @(posedge pclk) begin
        tcnt <= tcnt + 2'h1;
        timer1_ovf <= (tcnt == 2'h0);
        timer2_ovf <= (tcnt == 2'h2);
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= {4'h0, a};
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic t_reset;
        apb(usp_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(8'h14, 1'b0, 32'h0);
        chk(err, 1'b1);
    endtask : t_reset
    task automatic t_tx9;
        apb(usp_pkg::OFS_MASK, 1'b1, 32'h1);
        apb(usp_pkg::OFS_CTRL, 1'b1, 32'h88);
        fork
            i_node.recv(64, 9, fr);
            apb(usp_pkg::OFS_DATA, 1'b1, 32'hA5);
        join
        chk(fr, {1'b1, 1'b1, 8'hA5, 1'b0});
        chk(irq, 1'b1);
        apb(usp_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h8A);
        apb(usp_pkg::OFS_STS, 1'b1, 32'h1);
        apb(usp_pkg::OFS_STS, 1'b0, 32'h0);
        chk(irq, 1'b0);
    endtask : t_tx9
    task automatic t_rx9;
        apb(usp_pkg::OFS_RATE, 1'b1, 32'h2);
        apb(usp_pkg::OFS_CTRL, 1'b1, 32'hF0);
        i_node.send(64, 9, 9'h03C, 1'b1);
        apb(usp_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd[0], 1'b0);
        i_node.send(64, 9, 9'h15A, 1'b1);
        apb(usp_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd[2:0], 3'h5);
        apb(usp_pkg::OFS_DATA, 1'b0, 32'h0);
        chk(rd, 32'h5A);
    endtask : t_rx9
    task automatic t_rx8;
        apb(usp_pkg::OFS_RATE, 1'b1, 32'h0);
        apb(usp_pkg::OFS_CTRL, 1'b1, 32'h70);
        i_node.send(128, 8, 9'h011, 1'b0);
        apb(usp_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd[0], 1'b0);
        apb(usp_pkg::OFS_CTRL, 1'b1, 32'h54);
        i_node.send(128, 8, 9'h022, 1'b0);
        apb(usp_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk(rd[2:0], 3'h1);
        apb(usp_pkg::OFS_CTRL, 1'b1, 32'h75);
        i_node.send(128, 8, 9'h033, 1'b1);
        apb(usp_pkg::OFS_STS, 1'b0, 32'h0);
        chk(rd[2], 1'b1);
        apb(usp_pkg::OFS_CTRL, 1'b1, 32'h40);
        i_node.send(128, 8, 9'h044, 1'b1);
        apb(usp_pkg::OFS_DATA, 1'b0, 32'h0);
        chk(rd, 32'h33);
    endtask : t_rx8
    task automatic t_shift;
        n = 0;
        apb(usp_pkg::OFS_CTRL, 1'b1, 32'h0);
        fork
            apb(usp_pkg::OFS_DATA, 1'b1, 32'h96);
            repeat (24) begin
                @(negedge pclk);
                if (rxd_oe === 1'b1) begin
                    sh = {rxd_out, sh[7:1]};
                    n++;
                end
            end
        join
        chk(n, 8);
        chk(sh, 8'h96);
        i_node.drv <= 1'b0;
        apb(usp_pkg::OFS_CTRL, 1'b1, 32'h10);
        repeat (40) @(posedge pclk);
        apb(usp_pkg::OFS_DATA, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask : t_shift
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_tx9();
        t_rx9();
        t_rx8();
        t_shift();
        final_report();
    end
endmodule : tb
